// ==== bench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb import vss_pkg::*;;
    logic clk_sys = 1'b0;
    logic rstn, psel, penable, pwrite, pready, pslverr, conv_clk, host_bucket_pulse, bkt_req;
    logic sweep_active, ramp_past_level, peak_reset_enable, pos_holding, neg_holding;
    logic dac_above_video, conv_request, bucket_start, track_hold_ctl, guess_go;
    logic guess_finished_n, conversion_done_n, odd_bucket_flag, noise_flag, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, m;
    logic [RES_BITS-1:0] dac_code, video_level, go_code;
    logic [2:0] mux_sel;
    logic [9:0] ramp_level;
    logic [31:0] cyc = 0, t_st, t_th, t_go, t_fin, t_dn, t_cr, w_th, w_go, w_cr, i_cr;
    logic [31:0] n_th = 0, n_cr = 0;
    logic in_conv = 1'b0, p_st = 1'b0, p_th = 1'b0, p_go = 1'b0, p_cr = 1'b0;
    logic p_fin = 1'b1, p_dn = 1'b1;
    logic [7:0] mc [5] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'hB0};
    logic [2:0] ms [5] = '{3'h2, 3'h0, 3'h1, 3'h3, 3'h5};
    logic [11:0] vv [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'h5A3};
    int bad_count = 0;
    int n_checks = 0;
    always #4 clk_sys = ~clk_sys;
    vss_sequencer #(.NOISE_FAST_CYC(200), .NOISE_SLOW_CYC(900)) i_vss_sequencer (.*);
    vss_host_model i_vss_host_model (.*);
    // Edge timestamps of the conversion outputs
    always @(posedge clk_sys) begin
        cyc <= cyc + 32'h0000_0001;
        p_st <= conv_request | bucket_start;
        p_th <= track_hold_ctl;
        p_go <= guess_go;
        p_fin <= guess_finished_n;
        p_dn <= conversion_done_n;
        p_cr <= conv_request;
        if ((conv_request | bucket_start) && !p_st && !in_conv) begin
            t_st <= cyc;
            in_conv <= 1'b1;
        end
        if (conversion_done_n && !p_dn) in_conv <= 1'b0;
        if (track_hold_ctl && !p_th) t_th <= cyc;
        if (!track_hold_ctl && p_th) w_th <= cyc - t_th;
        n_th <= n_th + 32'(track_hold_ctl && !p_th);
        if (guess_go && !p_go) t_go <= cyc;
        if (guess_go && !p_go) go_code <= dac_code;
        if (!guess_go && p_go) w_go <= cyc - t_go;
        if (!guess_finished_n && p_fin) t_fin <= cyc;
        if (!conversion_done_n && p_dn) t_dn <= cyc;
        if (conv_request && !p_cr) t_cr <= cyc;
        if (conv_request && !p_cr) i_cr <= cyc - t_cr;
        if (!conv_request && p_cr) w_cr <= cyc - t_cr;
        n_cr <= n_cr + 32'(conv_request && !p_cr);
    end
    task automatic tally_and_finish();
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", s, x, g);
        end
    endtask : chk
    task automatic rng(input string s, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
        n_checks++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %s exp %0d..%0d got %0d", s, lo, hi, g);
        end
    endtask : rng
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic peak(input int k);
        repeat (k) begin
            peak_reset_enable <= 1'b1;
            @(posedge clk_sys);
            peak_reset_enable <= 1'b0;
            @(posedge clk_sys);
        end
        repeat (2) @(posedge clk_sys);
    endtask : peak
    task automatic pulse_bkt();
        bkt_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        bkt_req <= 1'b0;
        @(posedge clk_sys);
    endtask : pulse_bkt
    // A second pulse lands mid-conversion and must be ignored
    task automatic conv(input logic [11:0] v);
        logic [31:0] h;
        h = n_th;
        video_level <= v;
        pulse_bkt();
        repeat (1000) @(posedge clk_sys);
        pulse_bkt();
        while (in_conv === 1'b1) begin
            @(posedge clk_sys);
        end
        repeat (4) @(posedge clk_sys);
        rng("hold_on", 1875, 1882, t_th - t_st);
        rng("go_on", 2375, 2382, t_go - t_st);
        rng("hold_len", 2248, 2252, w_th);
        rng("go_len", 3868, 3880, w_go);
        rng("finished", 1375, 1510, t_fin - t_go);
        rng("done", 248, 252, t_dn - t_fin);
        chk("first_trial", 32'h0000_07FF, 32'(go_code));
        chk("holds", h + 1, n_th);
        chk("idle_n", 32'h0000_0003, {30'h0, guess_finished_n, conversion_done_n});
        apb(1'b0, REG_RESULT, 32'h0000_0000);
        chk("result", 32'(v), q);
    endtask : conv
    initial begin
        repeat (90000) @(posedge clk_sys);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, bkt_req} = '0;
        {sweep_active, ramp_past_level, peak_reset_enable, pos_holding, neg_holding} = '0;
        video_level = '0;
        rstn = 1'b0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        chk("rst_out", 32'h6080_0FFF, 32'({guess_finished_n, conversion_done_n, track_hold_ctl, guess_go,
            noise_flag, odd_bucket_flag, mux_sel, ramp_level, dac_code}));
        apb(1'b0, REG_PERIOD, 32'h0000_0000);
        chk("period", PERIOD_RESET, q);
        apb(1'b0, REG_CTRL, 32'h0000_0000);
        chk("ctrl", 32'(CTRL_RESET), q);
        apb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, REG_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0000, q);
        apb(1'b1, 8'h10, 32'h0000_00FF);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {q[30:0], e});
        foreach (mc[i]) begin
            apb(1'b1, REG_CTRL, 32'(mc[i]));
            repeat (3) @(posedge clk_sys);
            chk("mux", 32'(ms[i]), 32'(mux_sel));
        end
        apb(1'b1, REG_CTRL, 32'h0000_0008);
        peak(1);
        chk("cnt_1", 32'h0000_0401, {21'h0, odd_bucket_flag, ramp_level});
        peak(599);
        chk("cnt_600", 32'h0000_0258, {21'h0, odd_bucket_flag, ramp_level});
        peak(1);
        chk("cnt_wrap", 32'h0000_0000, {21'h0, odd_bucket_flag, ramp_level});
        peak(1);
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        peak(1);
        chk("narrow", 32'h0000_0001, 32'(ramp_level));
        {pos_holding, neg_holding} <= 2'b11;
        repeat (3) @(posedge clk_sys);
        {pos_holding, neg_holding} <= 2'b00;
        repeat (3) @(posedge clk_sys);
        chk("noise", 32'h0000_0001, 32'(noise_flag));
        peak(1);
        chk("noise_clr", 32'h0000_0000, 32'(noise_flag));
        apb(1'b1, REG_CTRL, 32'h0000_0004);
        foreach (vv[i]) conv(vv[i]);
        apb(1'b1, REG_CTRL, 32'h0000_0000);
        m = n_th;
        pulse_bkt();
        repeat (3000) @(posedge clk_sys);
        chk("no_zero_span", m, n_th);
        apb(1'b1, REG_PERIOD, 32'h0000_1B58);
        sweep_active <= 1'b1;
        repeat (16000) @(posedge clk_sys);
        rng("start_period", 6998, 7002, i_cr);
        rng("start_width", 1874, 1876, w_cr);
        sweep_active <= 1'b0;
        repeat (100) @(posedge clk_sys);
        m = n_cr;
        repeat (8000) @(posedge clk_sys);
        chk("retrace", m, n_cr);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire

// ==== bench/vss_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module vss_host_model import vss_pkg::*; (
    input wire logic clk_sys, // System clock
    input wire logic rstn, // Reset, active low
    input wire logic [RES_BITS-1:0] dac_code, // Trial code
    input wire logic [RES_BITS-1:0] video_level, // Sampled video
    input wire logic bkt_req, // Bench asks for a bucket pulse
    output logic conv_clk, // 1 MHz conversion clock
    output logic host_bucket_pulse, // Bucket pulse
    output logic dac_above_video // Comparator
);
    logic [6:0] div_q;
    // 125 system cycles per conversion clock
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_q <= 7'h00;
            host_bucket_pulse <= 1'b0;
        end else begin
            div_q <= (div_q == 7'h7C) ? 7'h00 : div_q + 7'h01;
            host_bucket_pulse <= bkt_req;
        end
    end
    assign conv_clk = div_q < 7'h3E;
    // Video sits just below its nominal code, so a DAC code at or above it exceeds it
    assign dac_above_video = dac_code >= video_level;
endmodule : vss_host_model
`default_nettype wire

// ==== src/vss_pkg.sv ====
package vss_pkg;

    // Clock and time base
    localparam int CLK_MHZ = 125;

    // Conversion timeline and start generator timing, in microseconds
    localparam int HOLD_ON_US = 15;
    localparam int HOLD_LEN_US = 18;
    localparam int GO_ON_US = 19;
    localparam int GO_LEN_US = 31;
    localparam int DONE_DLY_US = 2;
    localparam int START_PULSE_US = 15;
    localparam int NOISE_FAST_US = 130;
    localparam int NOISE_SLOW_US = 667;

    localparam int TL_W = 13;
    localparam logic [TL_W-1:0] HOLD_ON_CYC = TL_W'(HOLD_ON_US * CLK_MHZ);
    localparam logic [TL_W-1:0] HOLD_OFF_CYC = TL_W'((HOLD_ON_US + HOLD_LEN_US) * CLK_MHZ);
    localparam logic [TL_W-1:0] GO_ON_CYC = TL_W'(GO_ON_US * CLK_MHZ);
    localparam logic [TL_W-1:0] GO_OFF_CYC = TL_W'((GO_ON_US + GO_LEN_US) * CLK_MHZ);
    localparam logic [7:0] DONE_CYC = 8'(DONE_DLY_US * CLK_MHZ);
    localparam logic [31:0] START_PULSE_CYC = 32'(START_PULSE_US * CLK_MHZ);

    // Converter and bucket counter
    localparam int RES_BITS = 12;
    localparam logic [9:0] BUCKET_LAST = 10'h0258;
    localparam logic [3:0] GUESS_BITS = 4'hC;

    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PERIOD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0C;

    // Control field positions
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_ZERO_SPAN = 2;
    localparam int CTRL_WIDE_SWEEP = 3;
    localparam int CTRL_DIAG_EN = 4;
    localparam int CTRL_DIAG_SEL_LO = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [31:0] PERIOD_RESET = 32'h0001_45AF;

    // Detector modes
    localparam logic [1:0] MODE_SAMPLE = 2'h0;
    localparam logic [1:0] MODE_HIGHEST = 2'h1;
    localparam logic [1:0] MODE_LOWEST = 2'h2;
    localparam logic [1:0] MODE_NOISE = 2'h3;

    // Analog input selection
    localparam logic [2:0] MUX_POS_PEAK = 3'h0;
    localparam logic [2:0] MUX_LOWEST_READING_MODE = 3'h1;
    localparam logic [2:0] MUX_VIDEO = 3'h2;
    localparam logic [2:0] MUX_RAMP = 3'h3;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0001,
        SEQ_TRACK = 4'b0010,
        SEQ_GUESS = 4'b0100,
        SEQ_WRAP = 4'b1000
    } vss_state_t;

endpackage : vss_pkg

// ==== src/vss_sequencer.sv ====
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - A selected conversion request or a bucket start launches a conversion.
// - Track-hold control rises 15 us after the request.
// - Guess go rises 19 us after the request.
// - Track-hold stays high about 18 us, guess go about 31 us.
// - Guess finished goes low 12 conversion clocks after guess go rises.
// - Conversion done goes low 2 us after guess finished goes low.
// - Each bit is trialled in turn from the MSB by driving it low.
// - A trial bit stays low if the DAC is above video, else returns high.
// - All 12 bits are resolved, one per conversion clock.
// - On completion finished goes low and the result is readable on the bus.
// - The host bucket pulse triggers conversions only in zero span.
// - Sample mode issues 15 us starts every bucket period, only during sweep.
// - Noise mode issues starts every 130 us and every 667 us.
// - With noise flagged, noise mode alternates highest and lowest inputs.
// - One of eight analog inputs is selected for the converter.
// - The bucket counter runs only on wide sweeps.
// - On wide sweeps a bucket start is issued when the ramp passes the level of the count.
// - The bucket counter counts 0 to 600, 601 buckets per sweep.
// - On wide sweeps, each peak reset enable increments the bucket counter.
// - The odd bucket flag is the counter LSB.
// - In noise mode, noise is flagged when both peak holds are seen within one bucket.
module vss_sequencer import vss_pkg::*; #(
    parameter int NOISE_FAST_CYC = NOISE_FAST_US * CLK_MHZ,
    parameter int NOISE_SLOW_CYC = NOISE_SLOW_US * CLK_MHZ
) (
    input wire logic clk_sys, // System clock, 125 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic conv_clk, // Conversion clock from host
    input wire logic host_bucket_pulse, // Zero-span bucket pulse from host
    input wire logic sweep_active, // High during sweep, low in retrace
    input wire logic ramp_past_level, // Ramp above counter DAC level
    input wire logic peak_reset_enable, // Peak reset enable, one per bucket
    input wire logic pos_holding, // Positive peak holding indication
    input wire logic neg_holding, // Negative peak holding indication
    input wire logic dac_above_video, // Comparator: DAC above sampled video
    output logic conv_request, // Selected start source
    output logic bucket_start, // Bucket start pulse
    output logic track_hold_ctl, // Track-and-hold control
    output logic guess_go, // Successive-guess go
    output logic guess_finished_n, // Guess finished, active low
    output logic conversion_done_n, // Conversion done, active low
    output logic [RES_BITS-1:0] dac_code, // Trial code to the DAC
    output logic [2:0] mux_sel, // Analog input select
    output logic [9:0] ramp_level, // Bucket count to the ramp DAC
    output logic odd_bucket_flag, // Counter LSB
    output logic noise_flag // Noise seen in this bucket
);

    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction : rise

    vss_state_t state_q;
    logic [7:0] ctrl_q;
    logic [31:0] period_q;
    logic [TL_W-1:0] tl_q;
    logic hold_q, go_q, fin_n_q, done_n_q;
    logic [7:0] fin_age_q;
    logic [3:0] bit_idx_q;
    logic [3:0] tick_cnt_q;
    logic [RES_BITS-1:0] sar_q, result_q;
    logic conv_clk_prev_q, creq_q, creq_prev_q, bstart_q;
    logic host_prev_q, ramp_prev_q, pkr_prev_q;
    logic [9:0] count_q;
    logic seen_pos_q, seen_neg_q, noise_q;
    logic alt_q;
    logic [31:0] gen_cnt_q [2];
    logic [31:0] gen_per [2];
    logic [31:0] rdata_q;
    logic err_q;

    logic [1:0] mode;
    logic zero_span, wide_sweep, diag_en;
    logic conv_tick, start_evt, bucket_end, noise_mode;
    logic [1:0] gen_hit;

    assign mode = ctrl_q[CTRL_MODE_LO +: 2];
    assign zero_span = ctrl_q[CTRL_ZERO_SPAN];
    assign wide_sweep = ctrl_q[CTRL_WIDE_SWEEP];
    assign diag_en = ctrl_q[CTRL_DIAG_EN];
    assign noise_mode = (mode == MODE_NOISE);
    assign conv_tick = rise(conv_clk, conv_clk_prev_q);
    assign start_evt = rise(creq_q, creq_prev_q) | bstart_q;
    assign bucket_end = wide_sweep & rise(peak_reset_enable, pkr_prev_q);

    // APB slave, zero wait states
    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign pslverr = err_q & psel & penable;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= CTRL_RESET;
            period_q <= PERIOD_RESET;
        end else if (psel && penable && pwrite) begin
            if (paddr == REG_CTRL) begin
                ctrl_q <= pwdata[7:0];
            end else if (paddr == REG_PERIOD) begin
                period_q <= pwdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (psel && !penable) begin
            err_q <= 1'b0;
            if (paddr == REG_CTRL) begin
                rdata_q <= {24'h00_0000, ctrl_q};
            end else if (paddr == REG_PERIOD) begin
                rdata_q <= period_q;
            end else if (paddr == REG_STATUS) begin
                rdata_q <= {6'h00, count_q, 12'h000, alt_q, noise_flag, count_q[0], state_q != SEQ_IDLE};
            end else if (paddr == REG_RESULT) begin
                rdata_q <= {20'h0_0000, result_q};
            end else begin
                rdata_q <= 32'h0000_0000;
                err_q <= 1'b1;
            end
        end
    end

    // Edge history of the synchronous inputs
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            conv_clk_prev_q <= 1'b0;
            host_prev_q <= 1'b0;
            ramp_prev_q <= 1'b0;
            pkr_prev_q <= 1'b0;
            creq_prev_q <= 1'b0;
        end else begin
            conv_clk_prev_q <= conv_clk;
            host_prev_q <= host_bucket_pulse;
            ramp_prev_q <= ramp_past_level;
            pkr_prev_q <= peak_reset_enable;
            creq_prev_q <= creq_q;
        end
    end

    // Start pulse generators: slot 0 is the bucket-rate source (the slow noise source in noise mode), slot 1 the fast noise source
    always_comb begin
        gen_per[0] = noise_mode ? 32'(NOISE_SLOW_CYC) : period_q;
        gen_per[1] = 32'(NOISE_FAST_CYC);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 2; i++) begin
                gen_cnt_q[i] <= 32'h0000_0000;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!sweep_active || gen_cnt_q[i] + 32'h0000_0001 >= gen_per[i]) begin
                    gen_cnt_q[i] <= 32'h0000_0000;
                end else begin
                    gen_cnt_q[i] <= gen_cnt_q[i] + 32'h0000_0001;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            gen_hit[i] = sweep_active && gen_cnt_q[i] < START_PULSE_CYC;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            creq_q <= 1'b0;
            bstart_q <= 1'b0;
        end else begin
            creq_q <= gen_hit[0] | (noise_mode & gen_hit[1]);
            bstart_q <= (zero_span & rise(host_bucket_pulse, host_prev_q))
                | (wide_sweep & rise(ramp_past_level, ramp_prev_q));
        end
    end

    assign conv_request = creq_q;
    assign bucket_start = bstart_q;

    // Sequencing machine with its conversion timeline
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= SEQ_IDLE;
            tl_q <= '0;
        end else begin
            case (state_q)
                SEQ_IDLE: begin
                    if (start_evt) begin
                        state_q <= SEQ_TRACK;
                        tl_q <= '0;
                    end
                end
                SEQ_TRACK: begin
                    tl_q <= tl_q + 1'b1;
                    if (tl_q == GO_ON_CYC) begin
                        state_q <= SEQ_GUESS;
                    end
                end
                SEQ_GUESS: begin
                    if (tl_q != GO_OFF_CYC) begin
                        tl_q <= tl_q + 1'b1;
                    end
                    if (conv_tick && bit_idx_q == 4'h0) begin
                        state_q <= SEQ_WRAP;
                    end
                end
                SEQ_WRAP: begin
                    if (tl_q != GO_OFF_CYC) begin
                        tl_q <= tl_q + 1'b1;
                    end else if (!done_n_q) begin
                        state_q <= SEQ_IDLE;
                    end
                end
                default: begin
                    state_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hold_q <= 1'b0;
            go_q <= 1'b0;
        end else begin
            hold_q <= state_q != SEQ_IDLE && tl_q >= HOLD_ON_CYC && tl_q < HOLD_OFF_CYC;
            go_q <= state_q != SEQ_IDLE && tl_q >= GO_ON_CYC && tl_q < GO_OFF_CYC;
        end
    end

    assign track_hold_ctl = hold_q;
    assign guess_go = go_q;

    // Successive-guess machine, one decision per conversion clock
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sar_q <= '1;
            bit_idx_q <= 4'h0;
            tick_cnt_q <= 4'h0;
            result_q <= '0;
        end else if (state_q == SEQ_TRACK && tl_q == GO_ON_CYC) begin
            sar_q <= {1'b0, {(RES_BITS-1){1'b1}}};
            bit_idx_q <= GUESS_BITS - 4'h1;
            tick_cnt_q <= 4'h0;
        end else if (state_q == SEQ_GUESS && conv_tick) begin
            tick_cnt_q <= tick_cnt_q + 4'h1;
            if (bit_idx_q == 4'h0) begin
                result_q <= {sar_q[RES_BITS-1:1], ~dac_above_video};
                sar_q[0] <= ~dac_above_video;
            end else begin
                sar_q[bit_idx_q] <= ~dac_above_video;
                sar_q[bit_idx_q - 4'h1] <= 1'b0;
                bit_idx_q <= bit_idx_q - 4'h1;
            end
        end
    end

    assign dac_code = sar_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fin_n_q <= 1'b1;
            done_n_q <= 1'b1;
            fin_age_q <= 8'h00;
        end else if (state_q == SEQ_GUESS && conv_tick && bit_idx_q == 4'h0) begin
            fin_n_q <= 1'b0;
            fin_age_q <= 8'h00;
        end else if (state_q == SEQ_WRAP) begin
            if (fin_age_q != 8'hFF) begin
                fin_age_q <= fin_age_q + 8'h01;
            end
            if (fin_age_q == DONE_CYC - 8'h01) begin
                done_n_q <= 1'b0;
            end
        end else if (state_q == SEQ_IDLE) begin
            fin_n_q <= 1'b1;
            done_n_q <= 1'b1;
        end
    end

    assign guess_finished_n = fin_n_q;
    assign conversion_done_n = done_n_q;

    // Bucket counter and noise detection
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_q <= 10'h000;
        end else if (bucket_end) begin
            count_q <= (count_q == BUCKET_LAST) ? 10'h000 : count_q + 10'h001;
        end
    end

    assign ramp_level = count_q;
    assign odd_bucket_flag = count_q[0];

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            seen_pos_q <= 1'b0;
            seen_neg_q <= 1'b0;
            noise_q <= 1'b0;
        end else begin
            if (rise(peak_reset_enable, pkr_prev_q)) begin
                seen_pos_q <= pos_holding;
                seen_neg_q <= neg_holding;
            end else begin
                seen_pos_q <= seen_pos_q | pos_holding;
                seen_neg_q <= seen_neg_q | neg_holding;
            end
            noise_q <= (seen_pos_q | pos_holding) & (seen_neg_q | neg_holding);
        end
    end

    assign noise_flag = noise_q & noise_mode;

    // Input selection
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            alt_q <= 1'b0;
        end else if (state_q == SEQ_WRAP && tl_q == GO_OFF_CYC && !done_n_q) begin
            alt_q <= noise_flag ? ~alt_q : 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mux_sel <= MUX_VIDEO;
        end else if (diag_en) begin
            mux_sel <= ctrl_q[CTRL_DIAG_SEL_LO +: 3];
        end else if (wide_sweep && state_q == SEQ_IDLE) begin
            mux_sel <= MUX_RAMP;
        end else if (mode == MODE_SAMPLE) begin
            mux_sel <= MUX_VIDEO;
        end else if (mode == MODE_HIGHEST) begin
            mux_sel <= MUX_POS_PEAK;
        end else if (mode == MODE_LOWEST) begin
            mux_sel <= MUX_LOWEST_READING_MODE;
        end else begin
            mux_sel <= alt_q ? MUX_LOWEST_READING_MODE : MUX_POS_PEAK;
        end
    end

    a_hold_delay: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(track_hold_ctl) |-> tl_q == HOLD_ON_CYC + 1'b1)
        else $error("track hold rose at wrong time");

    a_go_delay: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(guess_go) |-> tl_q == GO_ON_CYC + 1'b1 && track_hold_ctl)
        else $error("guess go rose at wrong time");

    a_hold_width: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(track_hold_ctl) |-> tl_q == HOLD_OFF_CYC + 1'b1)
        else $error("track hold width wrong");

    a_go_width: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(guess_go) |-> tl_q == GO_OFF_CYC)
        else $error("guess go width wrong");

    a_guess_bits: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(guess_finished_n) |-> tick_cnt_q == GUESS_BITS && guess_go)
        else $error("finished without twelve guesses");

    a_done_delay: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(guess_finished_n) |-> conversion_done_n [*8] ##1 (fin_age_q <= DONE_CYC))
        else $error("done came too early");

    a_done_age: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(conversion_done_n) |-> fin_age_q == DONE_CYC && !guess_finished_n)
        else $error("done delay wrong");

    a_busy_ignore: assert property (@(posedge clk_sys) disable iff (!rstn)
        (start_evt && state_q != SEQ_IDLE && state_q != SEQ_WRAP) |=> tl_q != '0)
        else $error("start taken while busy");

    a_bucket_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
        (bucket_end && count_q == BUCKET_LAST) |=> count_q == 10'h000)
        else $error("bucket counter did not wrap");

    a_bucket_step: assert property (@(posedge clk_sys) disable iff (!rstn)
        (bucket_end && count_q != BUCKET_LAST) |=> count_q == $past(count_q) + 10'h001)
        else $error("bucket counter did not step");

    a_zero_span: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!zero_span && !wide_sweep) |=> !bucket_start)
        else $error("bucket start outside zero span");

    a_retrace_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
        !sweep_active ##1 !sweep_active |-> !conv_request)
        else $error("start pulse during retrace");

endmodule : vss_sequencer

`default_nettype wire
